// [pkg/serial_port_pkg.sv]
// Purpose: constants and types shared by the clock-synchronous serial port
// Assumes: APB slave, 32-bit data, one register per aligned word
// Notes:   register offsets are held as indices; byte address is four times the index
//
// Functional notes
// R1: mode bit 1 selects clock-synchronous operation
// R2: character length bit 0 means 8-bit characters
// R3: prescale 00, divisor 99 gives 100 kbit/s
// R4: tx empty request only when enable bit set
// R5: rx enable gates rx full and error requests
// R6: transmitter shifts only while tx enable set
// R7: receiver accepts data only while rx enable set
// R8: clock select 00 drives internal clock out
// R9: status register resets to 84 hex
// R10: writing 0 clears tx buffer empty flag
// R11: software writes control 00, then F0 later
// R12: rx full outranks tx empty by vector order
// R13: channel works only with module stop cleared
// R14: external clock taken from pin, no generator
// R15: transmit and receive are double buffered
// R16: prescaler divides by 1, 4, 16 or 64
// R17: buffer move to shifter sets empty flag again
// R18: one clock shifts byte out and in
package serial_port_pkg;

	// ----------------------------------------------------------------
	// register indices and byte addresses
	// ----------------------------------------------------------------
	localparam logic [31:0] SMR_IDX       = 32'hFFFFC000;
	localparam logic [31:0] BRR_IDX       = 32'hFFFFC002;
	localparam logic [31:0] SCR_IDX       = 32'hFFFFC004;
	localparam logic [31:0] TDR_IDX       = 32'hFFFFC006;
	localparam logic [31:0] SSR_IDX       = 32'hFFFFC008;
	localparam logic [31:0] RDR_IDX       = 32'hFFFFC00A;
	localparam logic [31:0] IRQ_STAT_IDX  = 32'hFFFFC00C;
	localparam logic [31:0] IRQ_MASK_IDX  = 32'hFFFFC00E;
	localparam logic [31:0] MSTOP_IDX     = 32'hFFFFC010;
	localparam logic [31:0] SMR_ADDR      = {SMR_IDX[29:0], 2'h0};
	localparam logic [31:0] BRR_ADDR      = {BRR_IDX[29:0], 2'h0};
	localparam logic [31:0] SCR_ADDR      = {SCR_IDX[29:0], 2'h0};
	localparam logic [31:0] TDR_ADDR      = {TDR_IDX[29:0], 2'h0};
	localparam logic [31:0] SSR_ADDR      = {SSR_IDX[29:0], 2'h0};
	localparam logic [31:0] RDR_ADDR      = {RDR_IDX[29:0], 2'h0};
	localparam logic [31:0] IRQ_STAT_ADDR = {IRQ_STAT_IDX[29:0], 2'h0};
	localparam logic [31:0] IRQ_MASK_ADDR = {IRQ_MASK_IDX[29:0], 2'h0};
	localparam logic [31:0] MSTOP_ADDR    = {MSTOP_IDX[29:0], 2'h0};

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int SMR_SYNC_BIT      = 7;
	localparam int SMR_LEN_BIT       = 6;
	localparam int SMR_PRESCALE_LSB  = 0;
	localparam int SCR_TX_IRQ_EN_BIT = 7;
	localparam int SCR_RX_IRQ_EN_BIT = 6;
	localparam int SCR_TX_EN_BIT     = 5;
	localparam int SCR_RX_EN_BIT     = 4;
	localparam int SCR_EXT_CLK_BIT   = 1;
	localparam int SSR_TX_EMPTY_BIT  = 7;
	localparam int SSR_RX_FULL_BIT   = 6;
	localparam int SSR_OVERRUN_BIT   = 5;
	localparam int SSR_TX_DONE_BIT   = 2;
	localparam int IRQ_RX_ERROR    = 0;
	localparam int IRQ_RX_FULL     = 1;
	localparam int IRQ_TX_EMPTY    = 2;
	localparam int IRQ_COUNT       = 3;

	// ----------------------------------------------------------------
	// reset values and counts
	// ----------------------------------------------------------------
	localparam logic [7:0] SMR_RESET   = 8'h00;
	localparam logic [7:0] BRR_RESET   = 8'hFF;
	localparam logic [7:0] SCR_RESET   = 8'h00;
	localparam logic [7:0] SSR_RESET   = 8'h84;
	localparam logic [7:0] DATA_RESET  = 8'h00;
	localparam logic       MSTOP_RESET = 1'b1;
	localparam logic [2:0] BIT_LAST    = 3'h7;
	localparam logic [5:0] PRESCALE_MAX [4] = '{6'h00, 6'h03, 6'h0F, 6'h3F};

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {SRC_NONE, SRC_RX_ERROR, SRC_RX_FULL, SRC_TX_EMPTY} irq_source_type;
	typedef enum logic {ENG_IDLE, ENG_RUN} engine_state_type;

endpackage

// [verilog/bit_rate_gen.sv]
// Purpose: internal serial clock generator, one pulse per half bit period
// Assumes: run low holds the counters cleared
// Notes:   half period is 2*(divisor+1) prescaled clocks
`timescale 1ns/1ps
module bit_rate_gen (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       ce,
	// control
	input  wire logic       run,
	input  wire logic [1:0] prescale_sel,
	input  wire logic [7:0] divisor,
	// strobe
	output logic            half_tick
);
	import serial_port_pkg::*;

	logic [5:0] pre_cnt;
	logic [8:0] div_cnt;
	logic       pre_tick;

	assign pre_tick = (pre_cnt == PRESCALE_MAX[prescale_sel]);  // [R16]

	always_ff @(posedge clock) begin
		if (!rst_n || !run) begin
			pre_cnt   <= 6'h00;
			div_cnt   <= 9'h000;
			half_tick <= 1'b0;
		end else if (ce) begin
			half_tick <= 1'b0;
			pre_cnt   <= pre_tick ? 6'h00 : pre_cnt + 6'h01;
			if (pre_tick) begin
				if (div_cnt == {divisor, 1'b1}) begin  // [R3]
					div_cnt   <= 9'h000;
					half_tick <= 1'b1;
				end else begin
					div_cnt <= div_cnt + 9'h001;
				end
			end
		end
	end

endmodule // bit_rate_gen

// [verilog/serial_port.sv]
// Purpose: clock-synchronous full-duplex serial port with APB registers
// Assumes: serial pins synchronous to clock; external clock slower than clock/4
// Notes:   asynchronous framing is not built; with the mode bit clear the channel idles
`timescale 1ns/1ps
module serial_port (
	// clock and reset
	input  wire logic                            clock,
	input  wire logic                            rst_n,
	input  wire logic                            ce,
	// apb slave
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic                            pwrite,
	input  wire logic [31:0]                     paddr,
	input  wire logic [31:0]                     pwdata,
	output logic      [31:0]                     prdata,
	output logic                                 pready,
	output logic                                 pslverr,
	// serial pins
	input  wire logic                            sck_in,
	output logic                                 sck_out,
	output logic                                 sck_oe,
	output logic                                 txd,
	input  wire logic                            rxd,
	// interrupts
	output logic                                 tx_empty_irq,
	output logic                                 rx_full_irq,
	output logic                                 rx_error_irq,
	output logic                                 irq,
	output serial_port_pkg::irq_source_type      irq_source
);
	import serial_port_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [7:0]             serial_mode_reg;
	logic [7:0]             bit_rate_reg;
	logic [7:0]             serial_control_reg;
	logic [7:0]             tx_data_reg;
	logic [7:0]             rx_data_reg;
	logic                   tx_buf_empty_flag;
	logic                   rx_full_flag;
	logic                   overrun_flag;
	logic                   tx_done_flag;
	logic [IRQ_COUNT-1:0]   irq_status;
	logic [IRQ_COUNT-1:0]   irq_mask;
	logic                   module_stop_bit;
	logic                   captured;
	engine_state_type       state;
	logic [2:0]             bit_cnt;
	logic [7:0]             tx_shift;
	logic [7:0]             rx_shift;
	logic                   tx_active;
	logic                   rx_active;
	logic                   sck_prev;
	logic                   half_tick;
	logic [31:0]            next_prdata;
	logic                   next_slverr;
	logic [IRQ_COUNT-1:0]   irq_event;
	logic [IRQ_COUNT-1:0]   pending;

	// ----------------------------------------------------------------
	// decoded controls
	// ----------------------------------------------------------------
	logic sync_mode;
	logic chan_on;
	logic ext_clk;
	logic tx_en;
	logic rx_en;
	logic tx_empty_irq_en;
	logic rx_full_irq_en;
	logic wr;
	logic chan_wr;
	logic next_tx;
	logic rx_only_go;
	logic rise;
	logic fall;
	logic byte_end;
	logic idle_start;
	logic tx_load;
	logic tx_done;
	logic rx_store;
	logic overrun;
	logic ssr_wr;
	logic [7:0] status_byte;

	assign sync_mode = serial_mode_reg[SMR_SYNC_BIT];                // [R1]
	assign chan_on   = !module_stop_bit && sync_mode;                // [R13]
	assign ext_clk         = serial_control_reg[SCR_EXT_CLK_BIT];
	assign tx_en           = serial_control_reg[SCR_TX_EN_BIT];
	assign rx_en           = serial_control_reg[SCR_RX_EN_BIT];
	assign tx_empty_irq_en = serial_control_reg[SCR_TX_IRQ_EN_BIT];
	assign rx_full_irq_en  = serial_control_reg[SCR_RX_IRQ_EN_BIT];

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	// read data is captured in the setup cycle so prdata comes from a flop
	assign pready  = ce && captured && psel && penable;
	assign wr      = pready && pwrite;
	// channel registers are frozen while the module is stopped
	assign chan_wr = wr && !module_stop_bit;                         // [R13]
	assign ssr_wr  = chan_wr && (paddr == SSR_ADDR);

	assign status_byte = {tx_buf_empty_flag, rx_full_flag, overrun_flag, 2'h0, tx_done_flag, 2'h0};

	always_comb begin
		next_prdata = 32'h00000000;
		next_slverr = 1'b0;
		case (paddr)
			SMR_ADDR:      next_prdata[7:0] = module_stop_bit ? 8'h00 : serial_mode_reg;
			BRR_ADDR:      next_prdata[7:0] = module_stop_bit ? 8'h00 : bit_rate_reg;
			SCR_ADDR:      next_prdata[7:0] = module_stop_bit ? 8'h00 : serial_control_reg;
			TDR_ADDR:      next_prdata[7:0] = module_stop_bit ? 8'h00 : tx_data_reg;
			SSR_ADDR:      next_prdata[7:0] = module_stop_bit ? 8'h00 : status_byte;
			RDR_ADDR:      next_prdata[7:0] = module_stop_bit ? 8'h00 : rx_data_reg;
			IRQ_STAT_ADDR: next_prdata[IRQ_COUNT-1:0] = irq_status;
			IRQ_MASK_ADDR: next_prdata[IRQ_COUNT-1:0] = irq_mask;
			MSTOP_ADDR:    next_prdata[0] = module_stop_bit;
			default:       next_slverr = 1'b1;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			captured <= 1'b0;
			prdata   <= 32'h00000000;
			pslverr  <= 1'b0;
		end else if (ce) begin
			captured <= psel && !penable;
			if (psel && !penable) begin
				prdata  <= pwrite ? 32'h00000000 : next_prdata;
				pslverr <= next_slverr;
			end
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			serial_mode_reg    <= SMR_RESET;
			bit_rate_reg       <= BRR_RESET;
			serial_control_reg <= SCR_RESET;
			tx_data_reg        <= DATA_RESET;
			irq_mask           <= '0;
			module_stop_bit    <= MSTOP_RESET;
		end else if (ce) begin
			if (chan_wr && paddr == SMR_ADDR)
				serial_mode_reg <= pwdata[7:0];
			if (chan_wr && paddr == BRR_ADDR)
				bit_rate_reg <= pwdata[7:0];
			// software is expected to load 00 first and enable only after setup
			if (chan_wr && paddr == SCR_ADDR)
				serial_control_reg <= pwdata[7:0];                       // [R11]
			if (chan_wr && paddr == TDR_ADDR)
				tx_data_reg <= pwdata[7:0];                              // [R15]
			if (wr && paddr == IRQ_MASK_ADDR)
				irq_mask <= pwdata[IRQ_COUNT-1:0];
			if (wr && paddr == MSTOP_ADDR)
				module_stop_bit <= pwdata[0];
		end
	end

	// ----------------------------------------------------------------
	// status flags: hardware set wins over a software clear
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			tx_buf_empty_flag <= SSR_RESET[SSR_TX_EMPTY_BIT];            // [R9]
			tx_done_flag      <= SSR_RESET[SSR_TX_DONE_BIT];             // [R9]
			rx_full_flag      <= SSR_RESET[SSR_RX_FULL_BIT];
			overrun_flag      <= SSR_RESET[SSR_OVERRUN_BIT];
		end else if (ce) begin
			if (tx_load)
				tx_buf_empty_flag <= 1'b1;                               // [R17]
			else if (ssr_wr && !pwdata[SSR_TX_EMPTY_BIT])
				tx_buf_empty_flag <= 1'b0;                               // [R10]
			if (tx_done)
				tx_done_flag <= 1'b1;
			else if (ssr_wr && !pwdata[SSR_TX_EMPTY_BIT])
				tx_done_flag <= 1'b0;
			if (rx_store)
				rx_full_flag <= 1'b1;
			else if (ssr_wr && !pwdata[SSR_RX_FULL_BIT])
				rx_full_flag <= 1'b0;
			if (overrun)
				overrun_flag <= 1'b1;
			else if (ssr_wr && !pwdata[SSR_OVERRUN_BIT])
				overrun_flag <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// clock selection and edges
	// ----------------------------------------------------------------
	// the generator only runs while a byte is in flight on the internal clock
	bit_rate_gen u_bit_rate_gen (
		.clock        (clock),
		.rst_n        (rst_n),
		.ce           (ce),
		.run          (chan_on && !ext_clk && state == ENG_RUN),       // [R14]
		.prescale_sel (serial_mode_reg[SMR_PRESCALE_LSB +: 2]),        // [R16]
		.divisor      (bit_rate_reg),                                  // [R3]
		.half_tick    (half_tick)
	);

	assign sck_oe = chan_on && !ext_clk;                               // [R8]

	always_ff @(posedge clock) begin
		if (!rst_n)
			sck_prev <= 1'b1;
		else if (ce)
			sck_prev <= sck_in;
	end

	always_comb begin
		if (ext_clk) begin
			fall = sck_prev && !sck_in;                                  // [R14]
			rise = !sck_prev && sck_in;
		end else begin
			fall = half_tick && sck_out;
			rise = half_tick && !sck_out;
		end
	end

	// ----------------------------------------------------------------
	// shift engine
	// ----------------------------------------------------------------
	// one clock moves both directions; rx alone waits for a free buffer
	assign next_tx    = chan_on && tx_en && !tx_buf_empty_flag;        // [R6]
	assign rx_only_go = chan_on && rx_en && !tx_en && !rx_full_flag;   // [R7]
	assign idle_start = (state == ENG_IDLE) && (next_tx || rx_only_go);
	// character length bit is ignored: synchronous characters are 8 bits
	assign byte_end   = (state == ENG_RUN) && chan_on && rise && (bit_cnt == BIT_LAST);  // [R2]
	assign tx_load    = (idle_start && next_tx) || (byte_end && tx_active && next_tx);    // [R17]
	assign tx_done    = byte_end && tx_active && !next_tx;
	assign rx_store   = byte_end && rx_active && !rx_full_flag;
	assign overrun    = byte_end && rx_active && rx_full_flag;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state     <= ENG_IDLE;
			bit_cnt   <= 3'h0;
			tx_shift  <= DATA_RESET;
			rx_shift  <= DATA_RESET;
			tx_active <= 1'b0;
			rx_active <= 1'b0;
			sck_out   <= 1'b1;
			txd       <= 1'b1;
		end else if (ce) begin
			case (state)
				ENG_IDLE: begin
					sck_out <= 1'b1;
					if (idle_start) begin
						state     <= ENG_RUN;
						bit_cnt   <= 3'h0;
						tx_active <= next_tx;                              // [R18]
						rx_active <= rx_en;                                // [R7]
						if (next_tx) begin
							tx_shift <= tx_data_reg;                       // [R15]
							txd      <= tx_data_reg[0];
						end
					end
				end
				ENG_RUN: begin
					if (!chan_on) begin
						state   <= ENG_IDLE;
						sck_out <= 1'b1;
						txd     <= 1'b1;
					end else if (fall) begin
						// parked high while the pin is an input
						sck_out <= ext_clk;                                // [R14]
						txd     <= tx_active ? tx_shift[0] : 1'b1;         // [R6]
					end else if (rise) begin
						sck_out  <= 1'b1;
						rx_shift <= {rxd, rx_shift[7:1]};                  // [R18]
						tx_shift <= {1'b1, tx_shift[7:1]};
						bit_cnt  <= bit_cnt + 3'h1;
						if (bit_cnt == BIT_LAST) begin
							bit_cnt <= 3'h0;
							if (tx_active && next_tx) begin
								tx_shift <= tx_data_reg;                   // [R15]
								rx_active <= rx_en;
							end else begin
								state <= ENG_IDLE;
							end
						end
					end
				end
				default: state <= ENG_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n)
			rx_data_reg <= DATA_RESET;
		else if (ce && rx_store)
			rx_data_reg <= {rxd, rx_shift[7:1]};                         // [R15]
	end

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	assign tx_empty_irq = chan_on && tx_empty_irq_en && tx_buf_empty_flag;  // [R4]
	assign rx_full_irq  = chan_on && rx_full_irq_en && rx_full_flag;        // [R5]
	assign rx_error_irq = chan_on && rx_full_irq_en && overrun_flag;        // [R5]

	assign irq_event[IRQ_TX_EMPTY] = tx_load && tx_empty_irq_en;       // [R4]
	assign irq_event[IRQ_RX_FULL]  = rx_store && rx_full_irq_en;       // [R5]
	assign irq_event[IRQ_RX_ERROR] = overrun && rx_full_irq_en;        // [R5]

	genvar gi;
	generate
		for (gi = 0; gi < IRQ_COUNT; gi++) begin : g_irq
			always_ff @(posedge clock) begin
				if (!rst_n)
					irq_status[gi] <= 1'b0;
				else if (ce) begin
					if (irq_event[gi])
						irq_status[gi] <= 1'b1;
					else if (wr && paddr == IRQ_STAT_ADDR && pwdata[gi])
						irq_status[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	assign pending = irq_status & irq_mask;
	assign irq     = |pending;

	// lower vector offset wins: error, then receive full, then transmit empty
	always_comb begin
		if (pending[IRQ_RX_ERROR])
			irq_source = SRC_RX_ERROR;                                   // [R12]
		else if (pending[IRQ_RX_FULL])
			irq_source = SRC_RX_FULL;                                    // [R12]
		else if (pending[IRQ_TX_EMPTY])
			irq_source = SRC_TX_EMPTY;
		else
			irq_source = SRC_NONE;
	end

endmodule // serial_port

// [tb/serial_port_monitor.sv]
// Purpose: port checks of the serial port
// Assumes: one clock domain, synchronous active-low reset
// Notes:   the shortest serial clock half period is 2 cycles
`timescale 1ns/1ps
module serial_port_monitor
	import serial_port_pkg::*;
(
	// clock and reset
	input wire logic                            clock,
	input wire logic                            rst_n,
	input wire logic                            ce,
	// apb
	input wire logic                            psel,
	input wire logic                            penable,
	input wire logic [31:0]                     paddr,
	input wire logic                            pready,
	input wire logic                            pslverr,
	// serial and interrupts
	input wire logic                            sck_out,
	input wire logic                            sck_oe,
	input wire logic                            txd,
	input wire logic                            irq,
	input wire serial_port_pkg::irq_source_type irq_source
);
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic mapped;
	assign mapped = paddr inside {SMR_ADDR, BRR_ADDR, SCR_ADDR, TDR_ADDR, SSR_ADDR, RDR_ADDR,
		IRQ_STAT_ADDR, IRQ_MASK_ADDR, MSTOP_ADDR};
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	chk_pready_zero_wait: assert property (ce && psel && !penable ##1 ce && psel && penable |-> pready)
		else $error("no ready in access cycle");
	chk_slverr_unmapped: assert property (psel && penable && pready |-> pslverr == !mapped)
		else $error("error response does not match address map");
	chk_irq_source_set: assert property (irq == (irq_source != SRC_NONE))
		else $error("irq and source disagree");
	chk_reset_idle: assert property ($rose(rst_n) |-> txd && sck_out && !sck_oe && !irq)
		else $error("pins not idle after reset");
	chk_sck_parked: assert property (!sck_oe |-> sck_out)
		else $error("serial clock moves while not driven");
	chk_txd_on_rise: assert property (sck_oe && $rose(sck_out) |-> $stable(txd))
		else $error("data changed on clock rise");
	chk_low_half: assert property (sck_oe && $fell(sck_out) |=> !sck_out)
		else $error("low half shorter than 2 cycles");
	chk_high_half: assert property (sck_oe && $rose(sck_out) |=> sck_out)
		else $error("high half shorter than 2 cycles");
	cover property (sck_oe && $fell(sck_out));
	cover property (psel && penable && pslverr);
	cover property (irq_source == SRC_RX_FULL);
	cover property (irq_source == SRC_RX_ERROR);
endmodule // serial_port_monitor

// [tb/serial_peer.sv]
// Purpose: clock-synchronous peer on the far side of the serial pins
// Assumes: sck made by the port, synchronous to clock
// Notes:   data driven after each sck fall, sampled at each rise, LSB first
`timescale 1ns/1ps
module serial_peer (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rst_n,
	// serial pins
	input  wire logic       sck,
	input  wire logic       txd,
	output logic            rxd,
	// byte side
	input  wire logic [7:0] tx_byte,
	output logic      [7:0] rx_byte,
	output logic      [7:0] count
);
	logic       sck_d;
	logic [2:0] nb;
	logic [7:0] sh;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sck_d <= 1'b1;
			nb <= 3'h0;
			sh <= 8'h00;
			rx_byte <= 8'h00;
			count <= 8'h00;
			rxd <= 1'b1;
		end else begin
			sck_d <= sck;
			if (sck_d && !sck)
				rxd <= tx_byte[nb];
			if (!sck_d && sck) begin
				sh <= {txd, sh[7:1]};
				nb <= nb + 3'h1;
				if (nb == 3'h7) begin
					rx_byte <= {txd, sh[7:1]};
					count <= count + 8'h01;
					// hold time over: no stale value left on the line
					rxd <= ~rxd;
				end
			end
		end
	end
endmodule // serial_peer

// [tb/serial_port_tb.sv]
// Purpose: self-checking bench of the serial port
// Assumes: 40 MHz clock, peer on the serial pins
// Notes:   short bit-rate divisors keep frames brief
`timescale 1ns/1ps
module serial_port_tb;
	import serial_port_pkg::*;
	logic           clock, rst_n, psel, penable, pwrite, sck_in, rxd, sck_out, sck_oe, txd;
	logic           pready, pslverr, tx_empty_irq, rx_full_irq, rx_error_irq, irq, e, sck_d, ce;
	logic [31:0]    paddr, pwdata, prdata, rd;
	logic [7:0]     peer_tx, peer_rx, peer_cnt;
	irq_source_type irq_source;
	int             errors, n_compared, cyc, nf, f1, f2;
	int             dv[4] = '{1, 4, 16, 64};
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	serial_port dut (.clock, .rst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .sck_in, .sck_out, .sck_oe, .txd, .rxd, .tx_empty_irq, .rx_full_irq,
		.rx_error_irq, .irq, .irq_source);
	serial_peer peer (.clock, .rst_n, .sck(sck_oe ? sck_out : sck_in), .txd, .rxd, .tx_byte(peer_tx),
		.rx_byte(peer_rx), .count(peer_cnt));
	// falls of the serial clock, for period measurement
	always @(posedge clock) begin
		cyc <= cyc + 1;
		sck_d <= sck_out;
		if (sck_d && !sck_out) begin
			f1 <= f2;
			f2 <= cyc;
			nf <= nf + 1;
		end
	end
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task end_of_test;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] g, x);
		n_compared++;
		if (g !== x) begin
			errors++;
			$display("BAD t=%0t got %h exp %h", $time, g, x);
		end
	endtask
	task tmo(input int n, m);
		if (n >= m) begin
			errors++;
			end_of_test;
		end
	endtask
	// one transfer then one idle cycle, so strobes never get two values in a step
	task bus(input logic w, input logic [31:0] a, d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		tmo(n, 20);
		@(posedge clock);
	endtask
	task wr(input logic [31:0] a, d);
		bus(1'b1, a, d);
	endtask
	task rdc(input logic [31:0] a, x);
		bus(1'b0, a, 32'h0);
		chk(rd, x);
	endtask
	task cfg(input logic [1:0] ps, input logic [7:0] brr, scr);
		wr(SCR_ADDR, 32'h00);
		wr(SMR_ADDR, {24'h0, 6'h20, ps} << 0 | 32'h80);
		wr(BRR_ADDR, {24'h0, brr});
		wr(SCR_ADDR, {24'h0, scr});
	endtask
	task send(input logic [7:0] d);
		wr(TDR_ADDR, {24'h0, d});
		wr(SSR_ADDR, 32'h04);
	endtask
	task wait_peer(input logic [7:0] c);
		int n;
		n = 0;
		while (peer_cnt !== c && n < 5000) begin
			@(posedge clock);
			n++;
		end
		tmo(n, 5000);
	endtask
	task period(input int x);
		int n0, n;
		n0 = nf;
		n = 0;
		while (nf < n0 + 2 && n < 2000) begin
			@(posedge clock);
			n++;
		end
		tmo(n, 2000);
		chk(f2 - f1, x);
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_regs;
		rdc(SSR_ADDR, 32'h00);
		wr(MSTOP_ADDR, 32'h00);
		rdc(SSR_ADDR, 32'h84);
		bus(1'b0, 32'h00000100, 32'h0);
		chk(e, 1'b1);
		$display("done regs");
	endtask
	task t_clock_src;
		cfg(2'h0, 8'h01, 8'h02);
		chk(sck_oe, 1'b0);
		cfg(2'h0, 8'h01, 8'h00);
		chk(sck_oe, 1'b1);
		$display("done clock source");
	endtask
	task t_gate;
		send(8'h77);
		bus(1'b0, SSR_ADDR, 32'h0);
		chk(rd[7], 1'b0);
		repeat (100) @(posedge clock);
		chk(peer_cnt, 8'h00);
		wr(SCR_ADDR, 32'h20);
		// clock enable low freezes the byte in flight
		ce <= 1'b0;
		repeat (100) @(posedge clock);
		chk(peer_cnt, 8'h00);
		ce <= 1'b1;
		wait_peer(8'h01);
		chk(peer_rx, 8'h77);
		bus(1'b0, SSR_ADDR, 32'h0);
		chk(rd[6], 1'b0);
		$display("done gate");
	endtask
	task t_stream;
		send(8'h11);
		send(8'h22);
		wait_peer(8'h02);
		chk(peer_rx, 8'h11);
		wait_peer(8'h03);
		chk(peer_rx, 8'h22);
		$display("done stream");
	endtask
	task t_rates;
		for (int p = 0; p < 4; p++) begin
			cfg(p[1:0], 8'h00, 8'h20);
			send(8'h5A + p[7:0]);
			period(4 * dv[p]);
			wait_peer(8'h04 + p[7:0]);
			chk(peer_rx, 8'h5A + p[7:0]);
			chk(tx_empty_irq, 1'b0);
			chk(rx_full_irq, 1'b0);
		end
		cfg(2'h0, 8'd99, 8'h20);
		send(8'hE1);
		period(400);
		wait_peer(8'h08);
		chk(peer_rx, 8'hE1);
		$display("done rates");
	endtask
	task t_duplex;
		cfg(2'h0, 8'h01, 8'hF0);
		wr(IRQ_MASK_ADDR, 32'h07);
		peer_tx <= 8'hC3;
		send(8'h96);
		repeat (4) @(posedge clock);
		chk(tx_empty_irq, 1'b1);
		wait_peer(8'h09);
		repeat (4) @(posedge clock);
		chk(rx_full_irq, 1'b1);
		chk(irq_source, SRC_RX_FULL);
		chk(peer_rx, 8'h96);
		rdc(RDR_ADDR, 32'hC3);
		wr(IRQ_MASK_ADDR, 32'h04);
		chk(irq_source, SRC_TX_EMPTY);
		wr(IRQ_MASK_ADDR, 32'h00);
		chk(irq, 1'b0);
		wr(IRQ_STAT_ADDR, 32'h07);
		wr(IRQ_MASK_ADDR, 32'h07);
		chk(irq, 1'b0);
		// receive buffer still full: the next byte is an overrun
		peer_tx <= 8'h5A;
		wr(TDR_ADDR, 32'h3C);
		wr(SSR_ADDR, 32'h44);
		wait_peer(8'h0A);
		repeat (4) @(posedge clock);
		chk(rx_error_irq, 1'b1);
		chk(irq_source, SRC_RX_ERROR);
		chk(peer_rx, 8'h3C);
		rdc(RDR_ADDR, 32'hC3);
		$display("done duplex");
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{errors, n_compared, cyc, nf, f1, f2} = '0;
		rst_n = 1'b0;
		sck_in = 1'b1;
		ce = 1'b1;
		peer_tx = 8'hA5;
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		t_regs;
		t_clock_src;
		t_gate;
		t_stream;
		t_rates;
		t_duplex;
		end_of_test;
	end
endmodule // serial_port_tb
bind serial_port serial_port_monitor mon (.clock, .rst_n, .ce, .psel, .penable, .paddr, .pready, .pslverr,
	.sck_out, .sck_oe, .txd, .irq, .irq_source);
